/* File: core/fsci_interp.sv */
`timescale 1ns/1ps
`include "fsci_regs.svh"
// Notes on behaviour
// - Key add, key select, key value commands each get a reply.
// - Optional auth string; absent means no name and no passkey.
// - Beacon timeout defaults 10s, pairing timeout 240s unless set.
// - Link frequency per channel; value FF disables that channel.
// - Pipe read request returns the commands held in the pipe.
// - Pipe write request stores the host command into the pipe.
// - Events are sent unrequested with the extended event identifier.
// - Codes 01 pairing request, 02 download start, 03 upload start.
// - Codes 04 download done, 05 upload done, 06 erase done.
// - Codes 07 link, 08 auth, 09 transport phase entry.
// - Codes 0A pipe command received, 0B pipe command processed.
// - Remote connect on one channel raises auth; others advertise busy.
// - After auth success, transport phase and transfer events follow.
// - Every extended identifier has its top three bits set.
// - Frame: A4, length, two id bytes, data, xor checksum.
module fsci_interp #(
  parameter int CHANNELS   = 8,
  parameter int PIPE_DEPTH = 16
) (
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire logic [7:0]          rx_byte_i,
  input  wire logic                rx_valid_i,
  output logic [7:0]               tx_byte_o,
  output logic                     tx_valid_o,
  input  wire logic                tx_ready_i,
  input  wire logic [CHANNELS-1:0] remote_connect_i,
  input  wire logic                auth_pass_i,
  input  wire logic [10:0]         occur_i,
  input  wire logic                pipe_done_i,
  output logic                     session_open_o,
  output logic [CHANNELS-1:0]      channel_enable_o,
  output logic [CHANNELS-1:0]      channel_busy_o,
  output logic [7:0]               beacon_timeout_o,
  output logic [7:0]               pairing_timeout_o,
  output logic                     auth_string_set_o,
  output logic                     pair_accept_o,
  output logic [7:0]               key_index_o,
  output logic                     key_value_used_o,
  output logic                     transport_o
);
  localparam int PW = $clog2(PIPE_DEPTH);
  default clocking sva_clk @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Receive side
  fsci_pkg::fsci_rx_t rx_state;
  logic [7:0]  rx_len;
  logic [7:0]  rx_cnt;
  logic [7:0]  rx_csum;
  logic [15:0] rx_id;
  logic [7:0]  rx_d0;
  logic [7:0]  rx_d1;
  logic [7:0]  pipe_mem [PIPE_DEPTH];
  logic [PW:0] pipe_cnt;
  logic [PW-1:0] pipe_wr;
  wire csum_ok   = (rx_csum == rx_byte_i);
  wire msg_done  = rx_valid_i && (rx_state == fsci_pkg::RX_CSUM) && csum_ok;
  wire ext_ok    = (rx_id[15:8] & `FSCI_EXT_ID_MASK) == `FSCI_EXT_ID_MASK;
  wire accept    = msg_done && ext_ok;
  wire data_in   = rx_valid_i && (rx_state == fsci_pkg::RX_DATA);
  wire pipe_push = data_in && (rx_id == `FSCI_ID_PIPE_WRITE)
                   && (pipe_cnt != PIPE_DEPTH[PW:0]);
  // Receive framing and checksum accumulation
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rx_state <= fsci_pkg::RX_SYNC;
      rx_len   <= 8'h00;
      rx_cnt   <= 8'h00;
      rx_csum  <= 8'h00;
      rx_id    <= 16'h0000;
      rx_d0    <= 8'h00;
      rx_d1    <= 8'h00;
    end
    else if (rx_valid_i)
    begin
      rx_csum <= rx_csum ^ rx_byte_i;
      case (rx_state)
        fsci_pkg::RX_SYNC:
        begin
          rx_csum <= rx_byte_i;
          if (rx_byte_i == `FSCI_SYNC_BYTE)
            rx_state <= fsci_pkg::RX_LEN;
        end
        fsci_pkg::RX_LEN:
        begin
          rx_len   <= rx_byte_i;
          rx_cnt   <= 8'h00;
          rx_state <= fsci_pkg::RX_IDH;
        end
        fsci_pkg::RX_IDH:
        begin
          rx_id[15:8] <= rx_byte_i;
          rx_state    <= fsci_pkg::RX_IDL;
        end
        fsci_pkg::RX_IDL:
        begin
          rx_id[7:0] <= rx_byte_i;
          rx_state   <= (rx_len == 8'h00) ? fsci_pkg::RX_CSUM : fsci_pkg::RX_DATA;
        end
        fsci_pkg::RX_DATA:
        begin
          if (rx_cnt == 8'h00)
            rx_d0 <= rx_byte_i;
          if (rx_cnt == 8'h01)
            rx_d1 <= rx_byte_i;
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_cnt + 8'h01 == rx_len)
            rx_state <= fsci_pkg::RX_CSUM;
        end
        fsci_pkg::RX_CSUM: rx_state <= fsci_pkg::RX_SYNC;
        default:           rx_state <= fsci_pkg::RX_SYNC;
      endcase
    end
  end
  // Pipe storage; a bad frame's bytes are kept, a known trade for a simple store
  // pipe write stores
  always_ff @(posedge clock_i)
  begin
    if (pipe_push)
      pipe_mem[pipe_wr] <= rx_byte_i;
  end
  // Transmit: reply, pipe dump or event
  logic        tx_start;
  logic [15:0] tx_id;
  logic [7:0]  tx_len;
  logic [7:0]  tx_data;
  logic [7:0]  tx_idx;
  logic        tx_busy;
  logic        reply_pend;
  logic [15:0] reply_id;
  logic        dump_pend;
  logic        dump_run;
  logic        ev_run;
  logic [7:0]  ev_code;
  logic [10:0] ev_pend;
  logic [10:0] ev_grant;
  logic [7:0]  pick_code;
  // Lowest pending event code goes first
  always_comb
  begin
    ev_grant  = 11'h000;
    pick_code = 8'h00;
    for (int i = 10; i >= 0; i--)
      if (ev_pend[i])
      begin
        ev_grant  = 11'h001 << i;
        pick_code = 8'(i + 1);
      end
  end

  // Launch when idle: replies beat pipe dumps beat events
  assign tx_start = !tx_busy && (reply_pend || dump_pend || ev_pend != 11'h000);
  assign tx_id    = reply_pend ? reply_id
                  : dump_pend ? `FSCI_ID_PIPE_READ : `FSCI_ID_EVENT;
  assign tx_len   = (dump_pend && !reply_pend) ? 8'(pipe_cnt) : 8'h01;
  assign tx_data  = dump_run ? pipe_mem[tx_idx[PW-1:0]]
                  : ev_run ? ev_code : `FSCI_REPLY_OK;
  fsci_tx u_tx (
    .clock_i      (clock_i),
    .sys_rst_i    (sys_rst_i),
    .start_i      (tx_start),
    .id_i         (tx_id),
    .len_i        (tx_len),
    .data_i       (tx_data),
    .data_idx_o   (tx_idx),
    .busy_o       (tx_busy),
    .byte_o       (tx_byte_o),
    .byte_valid_o (tx_valid_o),
    .byte_ready_i (tx_ready_i)
  );
  // Event sources: remote activity plus phase entries
  wire [10:0] ev_raise;
  wire        any_conn = |remote_connect_i;
  logic       conn_q;
  logic       auth_q;
  assign ev_raise[6:0]  = occur_i[6:0];
  assign ev_raise[7]    = occur_i[7] | (any_conn & !conn_q);
  assign ev_raise[8]    = occur_i[8] | (auth_pass_i & !auth_q);
  assign ev_raise[9]    = occur_i[9] | pipe_push & (rx_cnt + 8'h01 == rx_len);
  assign ev_raise[10]   = occur_i[10] | pipe_done_i;
  // Sticky event flags; a new raise wins over the grant that clears it
  // event codes
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      ev_pend <= 11'h000;
    else
      ev_pend <= (ev_pend & ~((tx_start && !reply_pend && !dump_pend) ? ev_grant : 11'h000))
                 | ev_raise;
  end
  // Send bookkeeping
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      reply_pend <= 1'b0;
      reply_id   <= 16'h0000;
      dump_pend  <= 1'b0;
      dump_run   <= 1'b0;
      ev_run     <= 1'b0;
      ev_code    <= 8'h00;
      conn_q     <= 1'b0;
      auth_q     <= 1'b0;
    end
    else
    begin
      conn_q <= any_conn;
      auth_q <= auth_pass_i;
      if (tx_start)
      begin
        dump_run <= !reply_pend && dump_pend;
        ev_run   <= !reply_pend && !dump_pend;
        ev_code  <= pick_code;
        if (reply_pend)
          reply_pend <= 1'b0;
        else if (dump_pend)
          dump_pend <= 1'b0;
      end
      if (accept && rx_id != `FSCI_ID_PIPE_READ && rx_id != `FSCI_ID_PIPE_WRITE)
      begin
        reply_pend <= 1'b1;
        reply_id   <= rx_id;
      end
      if (accept && rx_id == `FSCI_ID_PIPE_READ)
        dump_pend <= 1'b1;
    end
  end
  // Pipe occupancy; a dump drains it
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pipe_cnt <= '0;
      pipe_wr  <= '0;
    end
    else if (tx_start && !reply_pend && dump_pend)
    begin
      pipe_cnt <= '0;
      pipe_wr  <= '0;
    end
    else if (pipe_push)
    begin
      pipe_cnt <= pipe_cnt + 1'b1;
      pipe_wr  <= pipe_wr + 1'b1;
    end
  end
  // Configuration held from accepted commands; busy map and transport state follow the link inputs
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      session_open_o    <= 1'b0;
      channel_enable_o  <= '0;
      beacon_timeout_o  <= `FSCI_BEACON_TMO_RST;
      pairing_timeout_o <= `FSCI_PAIR_TMO_RST;
      auth_string_set_o <= 1'b0;
      pair_accept_o     <= 1'b0;
      key_index_o       <= 8'h00;
      key_value_used_o  <= 1'b0;
      transport_o       <= 1'b0;
      channel_busy_o    <= '0;
    end
    else
    begin
      if (accept)
        case (rx_id)
          `FSCI_ID_SESSION_OPEN:  session_open_o <= 1'b1;
          `FSCI_ID_SESSION_CLOSE: session_open_o <= 1'b0;
          `FSCI_ID_AUTH_STRING:   auth_string_set_o <= (rx_len != 8'h00);
          `FSCI_ID_BEACON_TMO:    beacon_timeout_o <= rx_d0;
          `FSCI_ID_PAIR_TMO:      pairing_timeout_o <= rx_d0;
          `FSCI_ID_PAIR_ANSWER:   pair_accept_o <= rx_d0[0];
          `FSCI_ID_KEY_SELECT:
          begin
            key_index_o      <= rx_d0;
            key_value_used_o <= 1'b0;
          end
          `FSCI_ID_KEY_VALUE:     key_value_used_o <= 1'b1;
          `FSCI_ID_LINK_FREQ:
            if (rx_d0 < 8'(CHANNELS))
              channel_enable_o[rx_d0[$clog2(CHANNELS)-1:0]] <= (rx_d1 != `FSCI_FREQ_OFF);
          default: ;
        endcase
      channel_busy_o <= any_conn ? ~remote_connect_i : '0;
      if (auth_pass_i)
        transport_o <= 1'b1;
      else if (!any_conn)
        transport_o <= 1'b0;
    end
  end
  bad_csum_a: assert property ((rx_valid_i && rx_state == fsci_pkg::RX_CSUM && !csum_ok)
    |=> !reply_pend || $past(reply_pend)) else $error("bad frame answered");
  key_reply_a: assert property ((accept && rx_id == `FSCI_ID_KEY_ADD)
    |=> reply_pend && reply_id == `FSCI_ID_KEY_ADD) else $error("key command not replied");
  freq_off_a: assert property (accept && rx_id == `FSCI_ID_LINK_FREQ
    && rx_d1 == `FSCI_FREQ_OFF && rx_d0 < 8'(CHANNELS)
    |=> !channel_enable_o[rx_d0[$clog2(CHANNELS)-1:0]]) else $error("channel not disabled");
  busy_other_a: assert property ($onehot(remote_connect_i)
    |=> channel_busy_o == ~$past(remote_connect_i)) else $error("busy map wrong");
  event_id_a: assert property ((tx_start && !reply_pend && !dump_pend)
    |-> tx_id == `FSCI_ID_EVENT) else $error("event wrong id");
  auth_entry_event_a: assert property ((any_conn && !conn_q) |=> ev_pend[7])
    else $error("auth_entry_event lost");
  xport_set_a: assert property ($rose(auth_pass_i) |=> transport_o && ev_pend[8])
    else $error("transport not entered");
  ext_id_a: assert property ((msg_done && !ext_ok && !reply_pend) |=> !reply_pend)
    else $error("non extended id answered");
endmodule

/* File: include/fsci_regs.svh */
`ifndef FSCI_REGS_SVH
`define FSCI_REGS_SVH

// Framing
`define FSCI_SYNC_BYTE        8'hA4
`define FSCI_EXT_ID_MASK      8'hE0
// Key management commands
`define FSCI_ID_KEY_ADD       16'hE245
`define FSCI_ID_KEY_SELECT    16'hE246
`define FSCI_ID_KEY_VALUE     16'hE247
// Session commands
`define FSCI_ID_SESSION_OPEN  16'hE231
`define FSCI_ID_SESSION_CLOSE 16'hE232
`define FSCI_ID_BEACON_CONFIG 16'hE233
`define FSCI_ID_AUTH_STRING   16'hE234
`define FSCI_ID_PAIR_ANSWER   16'hE236
`define FSCI_ID_LINK_FREQ     16'hE237
`define FSCI_ID_BEACON_TMO    16'hE238
`define FSCI_ID_PAIR_TMO      16'hE239
`define FSCI_ID_PIPE_READ     16'hE23B
`define FSCI_ID_PIPE_WRITE    16'hE23C
`define FSCI_ID_EVENT         16'hE000
// Event codes
`define FSCI_EV_PAIR_REQ      8'h01
`define FSCI_EV_DL_START      8'h02
`define FSCI_EV_UL_START      8'h03
`define FSCI_EV_DL_DONE       8'h04
`define FSCI_EV_UL_DONE       8'h05
`define FSCI_EV_ERASE_DONE    8'h06
`define FSCI_EV_LINK_PHASE    8'h07
`define FSCI_EV_AUTH_PHASE    8'h08
`define FSCI_EV_XPORT_PHASE   8'h09
`define FSCI_EV_PIPE_RX       8'h0A
`define FSCI_EV_PIPE_DONE     8'h0B
// Defaults
`define FSCI_BEACON_TMO_RST   8'h0A
`define FSCI_PAIR_TMO_RST     8'hF0
`define FSCI_FREQ_OFF         8'hFF
`define FSCI_REPLY_OK         8'h00

`endif

/* File: include/fsci_pkg.sv */
package fsci_pkg;
  typedef enum logic [3:0] {
    RX_SYNC, RX_LEN, RX_IDH, RX_IDL, RX_DATA, RX_CSUM
  } fsci_rx_t;
  typedef enum logic [3:0] {
    TX_IDLE, TX_SYNC, TX_LEN, TX_IDH, TX_IDL, TX_DATA, TX_CSUM
  } fsci_tx_t;
endpackage

/* File: core/fsci_tx.sv */
`timescale 1ns/1ps
`include "fsci_regs.svh"
// Outgoing frame builder: sync, length, id, payload, xor checksum
module fsci_tx (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] id_i,
  input  wire logic [7:0]  len_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_idx_o,
  output logic             busy_o,
  output logic [7:0]       byte_o,
  output logic             byte_valid_o,
  input  wire logic        byte_ready_i
);
  fsci_pkg::fsci_tx_t state;
  logic [7:0]  cnt;
  logic [7:0]  csum;
  logic [15:0] id_q;
  logic [7:0]  len_q;
  wire         take = byte_valid_o & byte_ready_i;

  // Byte currently presented
  always_comb
  begin
    case (state)
      fsci_pkg::TX_SYNC: byte_o = `FSCI_SYNC_BYTE;
      fsci_pkg::TX_LEN:  byte_o = len_q;
      fsci_pkg::TX_IDH:  byte_o = id_q[15:8];
      fsci_pkg::TX_IDL:  byte_o = id_q[7:0];
      fsci_pkg::TX_DATA: byte_o = data_i;
      fsci_pkg::TX_CSUM: byte_o = csum;
      default:           byte_o = 8'h00;
    endcase
  end
  assign byte_valid_o = (state != fsci_pkg::TX_IDLE);
  assign busy_o       = (state != fsci_pkg::TX_IDLE);
  assign data_idx_o   = cnt;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state <= fsci_pkg::TX_IDLE;
      cnt   <= 8'h00;
      csum  <= 8'h00;
      id_q  <= 16'h0000;
      len_q <= 8'h00;
    end
    else if (state == fsci_pkg::TX_IDLE)
    begin
      if (start_i)
      begin
        state <= fsci_pkg::TX_SYNC;
        id_q  <= id_i;
        len_q <= len_i;
        cnt   <= 8'h00;
        csum  <= 8'h00;
      end
    end
    else if (take)
    begin
      csum <= csum ^ byte_o;
      case (state)
        fsci_pkg::TX_SYNC: state <= fsci_pkg::TX_LEN;
        fsci_pkg::TX_LEN:  state <= fsci_pkg::TX_IDH;
        fsci_pkg::TX_IDH:  state <= fsci_pkg::TX_IDL;
        fsci_pkg::TX_IDL:  state <= (len_q == 8'h00) ? fsci_pkg::TX_CSUM : fsci_pkg::TX_DATA;
        fsci_pkg::TX_DATA:
        begin
          cnt <= cnt + 8'h01;
          if (cnt + 8'h01 == len_q)
            state <= fsci_pkg::TX_CSUM;
        end
        fsci_pkg::TX_CSUM: state <= fsci_pkg::TX_IDLE;
        default:           state <= fsci_pkg::TX_IDLE;
      endcase
    end
  end

  sync_first_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(busy_o) |-> byte_o == `FSCI_SYNC_BYTE) else $error("frame not opened by sync");
endmodule

/* File: sim/fsci_host_model.sv */
`timescale 1ns/1ps
// Host side of the serial message link
module fsci_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] dev_byte_i,
  input  wire logic       dev_valid_i,
  output logic            ready_o,
  output logic [7:0]      host_byte_o,
  output logic            host_valid_o
);
  logic [7:0] got_q[$];
  logic       slow = 1'b0;
  logic       phase = 1'b0;

  // Idle outputs from time zero
  initial
  begin
    ready_o = 1'b1;
    host_byte_o = 8'h00;
    host_valid_o = 1'b0;
  end

  // Collect device bytes; slow mode stalls every other cycle
  always @(posedge clock_i)
  begin
    if (dev_valid_i && ready_o)
      got_q.push_back(dev_byte_i);
    phase <= ~phase;
    #1 ready_o <= ~slow | phase;
  end

  task automatic build(input logic [15:0] id, input logic [7:0] d0, input logic [7:0] d1,
                       input int n, input logic bad, output logic [7:0] b[$]);
    logic [7:0] cs;
    b = '{8'hA4, n[7:0], id[15:8], id[7:0], d0};
    if (n == 2)
      b.push_back(d1);
    cs = 8'h00;
    foreach (b[k])
      cs ^= b[k];
    b.push_back(cs ^ {7'h00, bad});
  endtask

  // One pulse per byte; idle line shows the inverse
  task automatic send_frame(input logic [15:0] id, input logic [7:0] d0, input logic [7:0] d1,
                            input int n, input logic bad);
    logic [7:0] b[$];
    build(id, d0, d1, n, bad, b);
    foreach (b[k])
    begin
      @(posedge clock_i);
      #1;
      host_byte_o = b[k];
      host_valid_o = 1'b1;
      @(posedge clock_i);
      #1;
      host_valid_o = 1'b0;
      host_byte_o = ~b[k];
    end
  endtask
endmodule

/* File: sim/fsci_interp_tb_top.sv */
`timescale 1ns/1ps
module fsci_interp_tb_top;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] rx_byte;
  logic       rx_valid;
  logic [7:0] tx_byte;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] remote_connect = 8'h00;
  logic       auth_pass = 1'b0;
  logic [10:0] occur = 11'h000;
  logic       pipe_done = 1'b0;
  logic       s_open;
  logic [7:0] ch_en;
  logic [7:0] ch_busy;
  logic [7:0] b_tmo;
  logic [7:0] p_tmo;
  logic       auth_set;
  logic       p_acc;
  logic [7:0] k_idx;
  logic       k_used;
  logic       xport;
  int         n_fail = 0;
  int         compares = 0;

  // Free-running 200 MHz clock
  initial
  begin
    forever #2.5 clock_i = ~clock_i;
  end

  fsci_interp i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rx_byte_i(rx_byte), .rx_valid_i(rx_valid),
    .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .remote_connect_i(remote_connect), .auth_pass_i(auth_pass), .occur_i(occur),
    .pipe_done_i(pipe_done), .session_open_o(s_open), .channel_enable_o(ch_en),
    .channel_busy_o(ch_busy), .beacon_timeout_o(b_tmo), .pairing_timeout_o(p_tmo),
    .auth_string_set_o(auth_set), .pair_accept_o(p_acc), .key_index_o(k_idx),
    .key_value_used_o(k_used), .transport_o(xport)
  );

  fsci_host_model i_host (
    .clock_i(clock_i), .dev_byte_i(tx_byte), .dev_valid_i(tx_valid), .ready_o(tx_ready),
    .host_byte_o(rx_byte), .host_valid_o(rx_valid)
  );

  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait, then compare byte by byte
  task automatic exp_frame(input logic [15:0] id, input logic [7:0] d0, input logic [7:0] d1,
                           input int n);
    logic [7:0] e[$];
    int w;
    i_host.build(id, d0, d1, n, 1'b0, e);
    w = 0;
    while (i_host.got_q.size() < e.size() && w < 600)
    begin
      @(posedge clock_i);
      w++;
    end
    foreach (e[k])
      chk(i_host.got_q.size() > 0 ? i_host.got_q.pop_front() : ~e[k], e[k]);
  endtask

  // Command then its one-byte reply
  task automatic cmd(input logic [15:0] id, input logic [7:0] d0, input logic [7:0] d1,
                     input int n);
    i_host.send_frame(id, d0, d1, n, 1'b0);
    exp_frame(id, 8'h00, 8'h00, 1);
  endtask

  // Quiet spell, then nothing may have been sent
  task automatic quiet();
    repeat (60) @(posedge clock_i);
    chk(8'(i_host.got_q.size()), 8'h00);
  endtask

  task automatic t_reset();
    chk(b_tmo, 8'h0A);
    chk(p_tmo, 8'hF0);
    chk({7'h00, auth_set}, 8'h00);
    chk({6'h00, s_open, tx_valid}, 8'h00);
    chk(ch_en, 8'h00);
  endtask

  task automatic t_keys();
    cmd(16'hE245, 8'h02, 8'h00, 1);
    cmd(16'hE246, 8'h03, 8'h00, 1);
    chk(k_idx, 8'h03);
    cmd(16'hE247, 8'h5A, 8'h00, 1);
    chk({7'h00, k_used}, 8'h01);
  endtask

  // Host order: configure, names, timeouts, frequencies, open
  task automatic t_config();
    cmd(16'hE233, 8'h01, 8'h00, 1);
    cmd(16'hE234, 8'h41, 8'h00, 1);
    chk({7'h00, auth_set}, 8'h01);
    cmd(16'hE238, 8'h14, 8'h00, 1);
    cmd(16'hE239, 8'h3C, 8'h00, 1);
    chk(b_tmo, 8'h14);
    chk(p_tmo, 8'h3C);
    cmd(16'hE237, 8'h00, 8'h32, 2);
    cmd(16'hE237, 8'h01, 8'h20, 2);
    chk(ch_en, 8'h03);
    cmd(16'hE237, 8'h01, 8'hFF, 2);
    chk(ch_en, 8'h01);
    cmd(16'hE231, 8'h00, 8'h00, 1);
    chk({7'h00, s_open}, 8'h01);
  endtask

  task automatic t_refuse();
    i_host.send_frame(16'hE238, 8'h55, 8'h00, 1, 1'b1);
    quiet();
    chk(b_tmo, 8'h14);
    i_host.send_frame(16'h4238, 8'h55, 8'h00, 1, 1'b0);
    quiet();
    chk(b_tmo, 8'h14);
  endtask

  // Every event code, sink stalling
  task automatic t_events();
    i_host.slow = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clock_i);
      #1 occur = 11'h001 << i;
      @(posedge clock_i);
      #1 occur = 11'h000;
      exp_frame(16'hE000, 8'(i + 1), 8'h00, 1);
    end
    @(posedge clock_i);
    #1 pipe_done = 1'b1;
    @(posedge clock_i);
    #1 pipe_done = 1'b0;
    exp_frame(16'hE000, 8'h0B, 8'h00, 1);
    i_host.slow = 1'b0;
  endtask

  task automatic t_connect();
    #1 remote_connect = 8'h01;
    exp_frame(16'hE000, 8'h08, 8'h00, 1);
    chk(ch_busy, 8'hFE);
    cmd(16'hE236, 8'h01, 8'h00, 1);
    chk({7'h00, p_acc}, 8'h01);
    #1 auth_pass = 1'b1;
    exp_frame(16'hE000, 8'h09, 8'h00, 1);
    chk({7'h00, xport}, 8'h01);
  endtask

  task automatic t_pipe();
    i_host.send_frame(16'hE23C, 8'h11, 8'h22, 2, 1'b0);
    repeat (60) @(posedge clock_i);
    i_host.got_q.delete();
    i_host.send_frame(16'hE23B, 8'h00, 8'h00, 1, 1'b0);
    exp_frame(16'hE23B, 8'h11, 8'h22, 2);
    cmd(16'hE232, 8'h00, 8'h00, 1);
    chk({7'h00, s_open}, 8'h00);
  endtask

  // Watchdog far beyond the expected run
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    @(posedge clock_i);
    #1;
    t_reset();
    t_keys();
    t_config();
    t_refuse();
    t_events();
    t_connect();
    t_pipe();
    report_and_stop();
  end
endmodule
